// ---- hui_pkg.sv ----
`default_nettype none
package hui_pkg;
	// Speed select encoding
	localparam logic [7:0] HUI_SPEED_RESET = 8'h7A; // 115.2 kbit/s
	localparam logic [7:0] HUI_SPEED_MAX_CODE = 8'h15; // 1228.8 kbit/s, fastest allowed
	localparam int HUI_EXP_MSB = 7;
	localparam int HUI_EXP_LSB = 5;
	localparam int HUI_DIV_MSB = 4;
	localparam logic [12:0] HUI_LOW_OFFSET = 13'h001;
	localparam logic [12:0] HUI_HIGH_OFFSET = 13'h021;
	localparam logic [6:0] HUI_SPEED_ADDR = 7'h3B; // Device register address of the speed select

	// Rates in kHz: system clock of the speed formula and our own mclk
	localparam int HUI_SYS_KHZ = 27120;
	localparam int HUI_MCLK_KHZ = 25000;
	localparam logic [27:0] HUI_STEP = 28'(HUI_SYS_KHZ);

	// Character layout: start, eight data, stop
	localparam logic [3:0] HUI_LAST_DATA = 4'h8;
	localparam logic [3:0] HUI_LAST_BIT = 4'h9;

	// Address byte layout
	localparam int HUI_RW_BIT = 0;
	localparam logic HUI_RW_READ = 1'b1;

	// Host software registers
	localparam logic [1:0] HUI_REG_CMD = 2'h0;
	localparam logic [1:0] HUI_REG_SPEED = 2'h1;
	localparam logic [1:0] HUI_REG_STATUS = 2'h2;
	localparam logic [1:0] HUI_REG_RDATA = 2'h3;
	localparam int HUI_ST_BUSY = 0;
	localparam int HUI_ST_FULL = 1;
	localparam int HUI_ST_MISMATCH = 2;
	localparam int HUI_ST_REFUSED = 3;
	localparam int HUI_CMD_ABYTE_LSB = 8;

	// Bit period in units of 1/(SYS*MCLK): mclk cycles times HUI_SYS_KHZ
	function automatic logic [27:0] hui_bit_limit(input logic [7:0] code);
		logic [2:0] e;
		logic [12:0] n;
		e = code[HUI_EXP_MSB:HUI_EXP_LSB];
		if (e == 3'h0) begin
			n = 13'(code[HUI_DIV_MSB:0]) + HUI_LOW_OFFSET;
		end else begin
			n = (13'(code[HUI_DIV_MSB:0]) + HUI_HIGH_OFFSET) << (e - 3'h1);
		end
		return 28'(n) * 28'(HUI_MCLK_KHZ);
	endfunction
endpackage
`default_nettype wire

// ---- hui_link.sv ----
`default_nettype none
interface hui_link;
	logic h2d; // Host transmit, device receive
	logic d2h; // Device transmit, host receive
	logic host_line_three; // Read trigger
	modport dev(input h2d, input host_line_three, output d2h);
	modport host(output h2d, output host_line_three, input d2h);
endinterface
`default_nettype wire

// ---- hui_device.sv ----
`default_nettype none
module hui_serial (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] speed,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_start,
	output logic tx_ready
);
	logic rx_m_q, rx_s_q;
	logic rx_act_q, tx_act_q;
	logic [3:0] rx_cnt_q, tx_cnt_q;
	logic [27:0] rx_acc_q, rx_lim_q, tx_acc_q, tx_lim_q;
	logic [7:0] rx_sh_q;
	logic [9:0] tx_sh_q;
	logic [27:0] rx_sum, tx_sum;

	// Line is asynchronous to mclk
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
		end else begin
			rx_m_q <= rx_pin;
			rx_s_q <= rx_m_q;
		end
	end

	// Fractional accumulators keep the average rate exact despite 25 MHz mclk
	assign rx_sum = rx_acc_q + hui_pkg::HUI_STEP;
	assign tx_sum = tx_acc_q + hui_pkg::HUI_STEP;
	assign tx_ready = !tx_act_q;

	// Receiver, preloaded half a bit so ticks land mid-bit
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rx_act_q <= 1'b0;
			rx_cnt_q <= 4'h0;
			rx_acc_q <= 28'h0000000;
			rx_lim_q <= 28'h0000000;
			rx_sh_q <= 8'h00;
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_act_q) begin
				if (!rx_s_q) begin
					rx_act_q <= 1'b1;
					rx_cnt_q <= 4'h0;
					rx_lim_q <= hui_pkg::hui_bit_limit(speed);
					rx_acc_q <= hui_pkg::hui_bit_limit(speed) >> 1;
				end
			end else if (rx_sum >= rx_lim_q) begin
				rx_acc_q <= rx_sum - rx_lim_q;
				if (rx_cnt_q == 4'h0) begin
					// Glitch shorter than half a bit is dropped
					if (rx_s_q) begin
						rx_act_q <= 1'b0;
					end
					rx_cnt_q <= 4'h1;
				end else if (rx_cnt_q <= hui_pkg::HUI_LAST_DATA) begin
					rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
					rx_cnt_q <= rx_cnt_q + 4'h1;
				end else begin
					// Stop bit follows the eighth data bit, no parity slot
					rx_act_q <= 1'b0;
					if (rx_s_q) begin
						rx_byte <= rx_sh_q;
						rx_valid <= 1'b1;
					end
				end
			end else begin
				rx_acc_q <= rx_sum;
			end
		end
	end

	// Transmitter; speed latched per character so a change never splits one
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tx_act_q <= 1'b0;
			tx_cnt_q <= 4'h0;
			tx_acc_q <= 28'h0000000;
			tx_lim_q <= 28'h0000000;
			tx_sh_q <= 10'h3FF;
			tx_pin <= 1'b1;
		end else if (!tx_act_q) begin
			tx_pin <= 1'b1;
			if (tx_start) begin
				tx_act_q <= 1'b1;
				tx_cnt_q <= 4'h0;
				tx_acc_q <= 28'h0000000;
				tx_lim_q <= hui_pkg::hui_bit_limit(speed);
				tx_sh_q <= {1'b1, tx_byte, 1'b0};
				tx_pin <= 1'b0;
			end
		end else if (tx_sum >= tx_lim_q) begin
			tx_acc_q <= tx_sum - tx_lim_q;
			if (tx_cnt_q == hui_pkg::HUI_LAST_BIT) begin
				tx_act_q <= 1'b0;
				tx_pin <= 1'b1;
			end else begin
				tx_sh_q <= tx_sh_q >> 1;
				tx_pin <= tx_sh_q[1];
				tx_cnt_q <= tx_cnt_q + 4'h1;
			end
		end else begin
			tx_acc_q <= tx_sum;
		end
	end
endmodule

module hui_device (
	input wire logic mclk,
	input wire logic rst_n,
	hui_link.dev link,
	output logic [6:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] speed_select
);
	typedef enum logic [1:0] {
		HUI_D_IDLE = 2'b00,
		HUI_D_WDATA = 2'b01,
		HUI_D_READ = 2'b10
	} hui_dev_state_t;

	hui_dev_state_t state_q;
	logic l3_m_q, l3_s_q;
	logic [7:0] rx_byte, tx_byte_q;
	logic rx_valid, tx_start_q, tx_ready;

	hui_serial u_serial (
		.mclk(mclk),
		.rst_n(rst_n),
		.speed(speed_select),
		.rx_pin(link.h2d),
		.tx_pin(link.d2h),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid),
		.tx_byte(tx_byte_q),
		.tx_start(tx_start_q),
		.tx_ready(tx_ready)
	);

	// Read trigger comes from the host's clock domain
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			l3_m_q <= 1'b0;
			l3_s_q <= 1'b0;
		end else begin
			l3_m_q <= link.host_line_three;
			l3_s_q <= l3_m_q;
		end
	end

	// Access sequencer: address byte, then echo+data or read answer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= HUI_D_IDLE;
			reg_addr <= 7'h00;
			reg_wdata <= 8'h00;
			reg_we <= 1'b0;
			reg_re <= 1'b0;
			tx_byte_q <= 8'h00;
			tx_start_q <= 1'b0;
			speed_select <= hui_pkg::HUI_SPEED_RESET;
		end else begin
			reg_we <= 1'b0;
			reg_re <= 1'b0;
			tx_start_q <= 1'b0;
			unique case (state_q)
				HUI_D_IDLE: begin
					if (rx_valid) begin
						reg_addr <= rx_byte[7:1];
						if (rx_byte[hui_pkg::HUI_RW_BIT] == hui_pkg::HUI_RW_READ) begin
							// Without the trigger a read byte is ignored
							if (l3_s_q) begin
								reg_re <= 1'b1;
								state_q <= HUI_D_READ;
							end
						end else begin
							tx_byte_q <= rx_byte;
							tx_start_q <= 1'b1;
							state_q <= HUI_D_WDATA;
						end
					end
				end
				HUI_D_WDATA: begin
					// Receiver runs apart from the echo, so early data is kept
					if (rx_valid) begin
						if (reg_addr == hui_pkg::HUI_SPEED_ADDR) begin
							speed_select <= rx_byte;
						end else begin
							reg_wdata <= rx_byte;
							reg_we <= 1'b1;
						end
						state_q <= HUI_D_IDLE;
					end
				end
				HUI_D_READ: begin
					// User data is valid one cycle after the read strobe only, so skip the strobe cycle
					if (!reg_re) begin
						tx_byte_q <= (reg_addr == hui_pkg::HUI_SPEED_ADDR) ? speed_select : reg_rdata;
						tx_start_q <= tx_ready;
						if (tx_ready) begin
							state_q <= HUI_D_IDLE;
						end else begin
							reg_re <= 1'b1;
						end
					end
				end
				default: begin
					state_q <= HUI_D_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- hui_host.sv ----
`default_nettype none
module hui_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// Pointers wrap naturally, so depth must be a power of two
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
		$error("hui_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q;
	logic push, pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q];

	// Storage
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module hui_host #(
	parameter int CMD_DEPTH = 32
) (
	input wire logic mclk,
	input wire logic rst_n,
	hui_link.host link,
	input wire logic [1:0] sw_addr,
	input wire logic [15:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [15:0] sw_rdata
);
	typedef enum logic [1:0] {
		HUI_H_IDLE = 2'b00,
		HUI_H_ADDR = 2'b01,
		HUI_H_DATA = 2'b10,
		HUI_H_WAIT = 2'b11
	} hui_host_state_t;

	hui_host_state_t state_q;
	logic [7:0] speed_q, rx_byte, tx_byte_q, rdata_q;
	logic [15:0] cmd_q, fifo_data;
	logic tx_start_q, tx_ready, rx_valid, seen_q, mismatch_q, refused_q, line3_q;
	logic fifo_in_ready, fifo_valid, fifo_pop, cmd_wr, speed_ok;

	assign cmd_wr = sw_wr && (sw_addr == hui_pkg::HUI_REG_CMD);
	// Codes faster than the top supported rate are refused
	assign speed_ok = hui_pkg::hui_bit_limit(sw_wdata[7:0]) >= hui_pkg::hui_bit_limit(hui_pkg::HUI_SPEED_MAX_CODE);
	assign fifo_pop = (state_q == HUI_H_IDLE);
	assign link.host_line_three = line3_q;

	hui_fifo #(.WIDTH(16), .DEPTH(CMD_DEPTH)) u_cmd (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(cmd_wr),
		.in_ready(fifo_in_ready),
		.in_data(sw_wdata),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	hui_serial u_serial (
		.mclk(mclk),
		.rst_n(rst_n),
		.speed(speed_q),
		.rx_pin(link.d2h),
		.tx_pin(link.h2d),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid),
		.tx_byte(tx_byte_q),
		.tx_start(tx_start_q),
		.tx_ready(tx_ready)
	);

	// Software registers; hardware set beats read clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			speed_q <= hui_pkg::HUI_SPEED_RESET;
			refused_q <= 1'b0;
			sw_rdata <= 16'h0000;
		end else begin
			if (sw_wr && sw_addr == hui_pkg::HUI_REG_SPEED && speed_ok) begin
				speed_q <= sw_wdata[7:0];
			end
			if ((sw_wr && sw_addr == hui_pkg::HUI_REG_SPEED && !speed_ok) || (cmd_wr && !fifo_in_ready)) begin
				refused_q <= 1'b1;
			end else if (sw_rd && sw_addr == hui_pkg::HUI_REG_STATUS) begin
				refused_q <= 1'b0;
			end
			sw_rdata <= 16'h0000;
			if (sw_rd) begin
				unique case (sw_addr)
					hui_pkg::HUI_REG_CMD: sw_rdata <= cmd_q;
					hui_pkg::HUI_REG_SPEED: sw_rdata <= {8'h00, speed_q};
					hui_pkg::HUI_REG_STATUS: begin
						sw_rdata[hui_pkg::HUI_ST_BUSY] <= (state_q != HUI_H_IDLE) || fifo_valid;
						sw_rdata[hui_pkg::HUI_ST_FULL] <= !fifo_in_ready;
						sw_rdata[hui_pkg::HUI_ST_MISMATCH] <= mismatch_q;
						sw_rdata[hui_pkg::HUI_ST_REFUSED] <= refused_q;
					end
					hui_pkg::HUI_REG_RDATA: sw_rdata <= {8'h00, rdata_q};
				endcase
			end
		end
	end

	// Command engine: address byte, optional data byte, then one answer byte
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= HUI_H_IDLE;
			cmd_q <= 16'h0000;
			tx_byte_q <= 8'h00;
			tx_start_q <= 1'b0;
			line3_q <= 1'b0;
			seen_q <= 1'b0;
			rdata_q <= 8'h00;
			mismatch_q <= 1'b0;
		end else begin
			tx_start_q <= 1'b0;
			if (rx_valid) begin
				seen_q <= 1'b1;
				rdata_q <= rx_byte;
			end
			if (sw_rd && sw_addr == hui_pkg::HUI_REG_STATUS) begin
				mismatch_q <= 1'b0;
			end
			unique case (state_q)
				HUI_H_IDLE: begin
					if (fifo_valid) begin
						cmd_q <= fifo_data;
						seen_q <= 1'b0;
						// Trigger held for the whole read
						line3_q <= fifo_data[hui_pkg::HUI_CMD_ABYTE_LSB] == hui_pkg::HUI_RW_READ;
						state_q <= HUI_H_ADDR;
					end
				end
				HUI_H_ADDR: begin
					if (tx_ready) begin
						tx_byte_q <= cmd_q[15:8];
						tx_start_q <= 1'b1;
						state_q <= line3_q ? HUI_H_WAIT : HUI_H_DATA;
					end
				end
				HUI_H_DATA: begin
					// Sent without waiting for the echo
					if (tx_ready && !tx_start_q) begin
						tx_byte_q <= cmd_q[7:0];
						tx_start_q <= 1'b1;
						state_q <= HUI_H_WAIT;
					end
				end
				HUI_H_WAIT: begin
					if (seen_q && tx_ready && !tx_start_q) begin
						if (!line3_q && rdata_q != cmd_q[15:8]) begin
							mismatch_q <= 1'b1;
						end
						line3_q <= 1'b0;
						state_q <= HUI_H_IDLE;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- hui_checker.sv ----
`default_nettype none
module hui_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic h2d,
	input wire logic d2h,
	input wire logic host_line_three
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] h2d_low_q;
	logic [12:0] d2h_low_q;
	logic [12:0] quiet_q;
	logic seen_q;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// Low runs saturate, so a stuck line cannot wrap back into range
	always_ff @(posedge mclk) begin
		if (!rst_n || h2d) h2d_low_q <= 13'h0000;
		else if (h2d_low_q != 13'h1FFF) h2d_low_q <= h2d_low_q + 13'h0001;
	end
	always_ff @(posedge mclk) begin
		if (!rst_n || d2h) d2h_low_q <= 13'h0000;
		else if (d2h_low_q != 13'h1FFF) d2h_low_q <= d2h_low_q + 13'h0001;
	end
	// Cycles since the host line last moved
	always_ff @(posedge mclk) begin
		if (!rst_n || $changed(h2d)) quiet_q <= 13'h0000;
		else if (quiet_q != 13'h1FFF) quiet_q <= quiet_q + 13'h0001;
	end
	// Marks the end of the first low run after reset
	always_ff @(posedge mclk) begin
		if (!rst_n) seen_q <= 1'b0;
		else if ($rose(h2d)) seen_q <= 1'b1;
	end

	// Shortest legal bit is about 20 cycles
	sequence held_s(logic s);
		$stable(s) [*7];
	endsequence

	reset_idle_a: assert property ($rose(rst_n) |-> h2d && d2h && !host_line_three)
		else $error("serial lines not idle after reset");
	h2d_bit_a: assert property ($changed(h2d) |=> held_s(h2d))
		else $error("host line bit too short");
	d2h_bit_a: assert property ($changed(d2h) |=> held_s(d2h))
		else $error("device line bit too short");
	first_start_a: assert property ($rose(h2d) && !seen_q |-> h2d_low_q >= 13'h00D7 && h2d_low_q <= 13'h00DC)
		else $error("first start bit not at default speed");
	h2d_frame_a: assert property (h2d_low_q <= 13'h07B2)
		else $error("host line low past a character");
	d2h_frame_a: assert property (d2h_low_q <= 13'h07B2)
		else $error("device line low past a character");
	answer_bound_a: assert property ($fell(d2h) |-> quiet_q < 13'h1194)
		else $error("device sent without a request");
	trigger_hold_a: assert property (host_line_three && !d2h |=> host_line_three)
		else $error("read trigger dropped during answer");
endmodule
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] ab;
		logic [7:0] dat;
	} hui_row_t;
	// Address byte beside write data or the value the user side returns
	localparam hui_row_t ROWS [5] = '{'{8'h0B, 8'hA5}, '{8'h20, 8'h5A}, '{8'hFE, 8'hFF},
		'{8'h01, 8'h00}, '{8'hFF, 8'h81}};
	logic mclk, rst_n, sw_wr, sw_rd, reg_we, reg_re;
	logic [1:0] sw_addr;
	logic [15:0] sw_wdata, sw_rdata;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, speed_select, cur_code, last_wd, rd_val;
	int bad_count = 0;
	int num_checks = 0;
	int we_count = 0;
	int re_count = 0;
	int low_n = 0;
	int run_q = 0;

	hui_link link();
	hui_host i_hui_host (.mclk(mclk), .rst_n(rst_n), .link(link.host), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	hui_device i_hui_device (.mclk(mclk), .rst_n(rst_n), .link(link.dev), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.speed_select(speed_select));
	hui_checker i_hui_checker (.mclk(mclk), .rst_n(rst_n), .h2d(link.h2d), .d2h(link.d2h),
		.host_line_three(link.host_line_three));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// User-side tallies and the last host-line low run
	always @(posedge mclk) begin
		if (reg_we) we_count <= we_count + 1;
		if (reg_we) last_wd <= reg_wdata;
		if (reg_re) re_count <= re_count + 1;
		// Registered user slave: answer stands only in the cycle after the strobe
		reg_rdata <= reg_re ? rd_val : 8'h00;
		if (!link.h2d) low_n <= low_n + 1;
		else if (low_n != 0) begin
			run_q <= low_n;
			low_n <= 0;
		end
	end

	function automatic real bit_cyc(input logic [7:0] c);
		int n;
		n = (c[7:5] == 3'h0) ? int'(c[4:0]) + 1 : (int'(c[4:0]) + 33) << (c[7:5] - 1);
		return n * real'(hui_pkg::HUI_MCLK_KHZ) / real'(hui_pkg::HUI_SYS_KHZ);
	endfunction

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Strobe gap of one cycle keeps each strobe a clean pulse
	task automatic sw_w(input logic [1:0] a, input logic [15:0] d);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge mclk);
		sw_wr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic sw_r(input logic [1:0] a, output logic [15:0] d);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge mclk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
		@(posedge mclk);
	endtask

	task automatic idle(output logic [15:0] s);
		int n;
		n = 0;
		repeat (4) @(posedge mclk);
		do begin
			sw_r(hui_pkg::HUI_REG_STATUS, s);
			n++;
		end while (s[hui_pkg::HUI_ST_BUSY] !== 1'b0 && n < 40000);
		chk("busy", 16'h0000, 16'(s[hui_pkg::HUI_ST_BUSY]));
	endtask

	task automatic xfer(input logic [7:0] ab, input logic [7:0] dat);
		logic [15:0] s, r;
		int w0, r0;
		logic spd;
		w0 = we_count;
		r0 = re_count;
		spd = ab[7:1] == hui_pkg::HUI_SPEED_ADDR;
		rd_val <= dat;
		sw_w(hui_pkg::HUI_REG_CMD, {ab, dat});
		idle(s);
		sw_r(hui_pkg::HUI_REG_RDATA, r);
		chk("reg_addr", 16'(ab[7:1]), 16'(reg_addr));
		chk("writes", 16'(w0 + int'(!ab[0] && !spd)), 16'(we_count));
		if (!spd) chk("reads", 16'(r0 + int'(ab[0])), 16'(re_count));
		chk("mismatch", 16'h0000, 16'(s[hui_pkg::HUI_ST_MISMATCH]));
		if (ab[0]) chk("rdata", 16'(spd ? cur_code : dat), r);
		else chk("echo", 16'(ab), r);
		if (!ab[0] && !spd) chk("wdata", 16'(dat), 16'(last_wd));
	endtask

	// Device first, then host, then a read at the new speed
	task automatic set_speed(input logic [7:0] c);
		xfer({hui_pkg::HUI_SPEED_ADDR, 1'b0}, c);
		chk("speed_select", 16'(c), 16'(speed_select));
		sw_w(hui_pkg::HUI_REG_SPEED, 16'(c));
		cur_code = c;
		xfer({hui_pkg::HUI_SPEED_ADDR, 1'b1}, 8'h00);
		chk("bit_time", 16'h0001, 16'(run_q > bit_cyc(c) - 1.5 && run_q < bit_cyc(c) + 1.5));
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		// Tests need about 46k cycles; margin stays under the run budget
		#(80000 * 40);
		bad_count++;
		$display("[ERR] watchdog expected done seen hang");
		wrap_up();
	end

	initial begin
		logic [15:0] s;
		int w0;
		rst_n = 1'b0;
		sw_addr = 2'h0;
		sw_wdata = 16'h0000;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		rd_val = 8'h00;
		cur_code = 8'h7A;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("speed_select", 16'h007A, 16'(speed_select));
		sw_r(hui_pkg::HUI_REG_SPEED, s);
		chk("speed", 16'h007A, s);
		sw_r(hui_pkg::HUI_REG_STATUS, s);
		chk("status", 16'h0000, s);
		foreach (ROWS[i]) xfer(ROWS[i].ab, ROWS[i].dat);
		set_speed(8'h1C);
		set_speed(8'h15);
		// Codes faster than the ceiling must be dropped
		foreach (ROWS[i]) if (i < 2) begin
			sw_w(hui_pkg::HUI_REG_SPEED, i ? 16'h0000 : 16'h0014);
			sw_r(hui_pkg::HUI_REG_SPEED, s);
			chk("speed", 16'h0015, s);
			sw_r(hui_pkg::HUI_REG_STATUS, s);
			chk("refused", 16'h0001, 16'(s[hui_pkg::HUI_ST_REFUSED]));
			sw_r(hui_pkg::HUI_REG_STATUS, s);
			chk("refused", 16'h0000, 16'(s[hui_pkg::HUI_ST_REFUSED]));
		end
		// Overfill the command queue back to back
		w0 = we_count;
		sw_addr <= hui_pkg::HUI_REG_CMD;
		sw_wr <= 1'b1;
		for (int i = 0; i < 34; i++) begin
			sw_wdata <= {8'h40, 8'(i)};
			@(posedge mclk);
		end
		sw_wr <= 1'b0;
		@(posedge mclk);
		sw_r(hui_pkg::HUI_REG_STATUS, s);
		chk("full", 16'h0001, 16'(s[hui_pkg::HUI_ST_FULL]));
		chk("refused", 16'h0001, 16'(s[hui_pkg::HUI_ST_REFUSED]));
		idle(s);
		chk("drained", 16'h0021, 16'(we_count - w0));
		set_speed(8'h7A);
		wrap_up();
	end
endmodule
`default_nettype wire
